// ===== bench/host_model.sv
/* link host model: offers one command, waits for its answer.
 assumes link_clk from the bench and the command port handshake. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// answer side
	input  wire logic        link_clk,
	input  wire logic        cmd_ready,
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data,
	// request side
	output logic             cmd_valid,
	output logic [7:0]       cmd_code,
	output logic             cmd_write,
	output logic             cmd_page,
	output logic [15:0]      cmd_wdata,
	output logic             hung
);
	initial begin
		{cmd_valid, cmd_write, cmd_page, hung} = 4'h0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// one whole word, one outstanding
	task automatic xfer(input logic [7:0] c, input logic w, input logic p,
		input logic [15:0] d, output logic [15:0] r);
		int n = 0;
		@(posedge link_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_write <= w;
		cmd_page <= p;
		cmd_wdata <= d;
		do @(posedge link_clk); while (cmd_ready !== 1'b1 && n++ < 50);
		cmd_valid <= 1'b0;
		// released lines flip, so stale values never look valid
		cmd_code <= ~c;
		cmd_write <= ~w;
		cmd_page <= ~p;
		cmd_wdata <= ~d;
		do @(posedge link_clk); while (rsp_valid !== 1'b1 && n++ < 50);
		r = rsp_data;
		if (n >= 50) hung = 1'b1;
	endtask
endmodule // host_model
`default_nettype wire

// ===== bench/tb_top.sv
/* randomised bench for the telemetry bank, self-checking.
 assumes the host model drives the link port. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        ref_clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1;
	logic        cmd_valid, cmd_ready, cmd_write, cmd_page, rsp_valid, hung;
	logic        adc_valid, cml_invalid_data, ecc_refresh, ecc_corrected, resv;
	logic [7:0]  cmd_code, adc_param, adc_select, c;
	logic [15:0] cmd_wdata, rsp_data, adc_value, duty_ch0, duty_ch1, freq_khz;
	logic [15:0] iin_offset_ch0, iin_offset_ch1, r, v, vmax;
	logic [4:0]  vout_exponent;
	logic [7:0]  prm [4] = '{8'h01, 8'h04, 8'h0c, 8'h0a};
	logic [7:0]  cmds [4] = '{8'h88, 8'h8e, 8'h8d, 8'h8c};
	logic [7:0]  pks [4] = '{8'hde, 8'hf4, 8'hdf, 8'hd7};
	int          fail_count = 0, comparisons = 0, seed = 32'h713b5347;
	always #5 ref_clk = ~ref_clk;
	always #24 link_clk = ~link_clk;
	telemetry_readback_bank dut_u (
		.ref_clk(ref_clk), .link_clk(link_clk), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
		.cmd_write(cmd_write), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .adc_valid(adc_valid),
		.adc_param(adc_param), .adc_value(adc_value), .adc_select(adc_select),
		.cml_invalid_data(cml_invalid_data), .duty_ch0(duty_ch0), .duty_ch1(duty_ch1),
		.freq_khz(freq_khz), .vout_exponent(vout_exponent),
		.iin_offset_ch0(iin_offset_ch0), .iin_offset_ch1(iin_offset_ch1),
		.ecc_refresh(ecc_refresh), .ecc_corrected(ecc_corrected)
	);
	host_model host_u (
		.link_clk(link_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_write(cmd_write), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .hung(hung)
	);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic adc(input logic [7:0] p, input logic [15:0] val);
		@(posedge ref_clk);
		adc_valid <= 1'b1;
		adc_param <= p;
		adc_value <= val;
		@(posedge ref_clk);
		adc_valid <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] cc, input logic p);
		host_u.xfer(cc, 1'b0, p, 16'h0000, r);
	endtask
	task automatic wr(input logic [7:0] cc, input logic [15:0] d);
		host_u.xfer(cc, 1'b1, 1'b0, d, r);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// numeric value of a linear word; encodings of one value may differ
	function automatic int l11_int(input logic [15:0] x);
		return $rtoi($itor($signed(x[10:0])) * (2.0 ** $signed(x[15:11])));
	endfunction
	// a timed-out transfer ends the run as a mismatch
	always @(posedge link_clk) begin
		if (hung === 1'b1) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		{adc_valid, ecc_refresh, ecc_corrected} = 3'h0;
		{adc_param, adc_value, duty_ch0, duty_ch1, freq_khz} = '0;
		{vout_exponent, iin_offset_ch0, iin_offset_ch1} = '0;
		// six link edges of reset, so count the slower clock
		repeat (6) @(posedge link_clk);
		sys_rst <= 1'b0;
		rd(telemetry_pkg::CMD_EXTRA_STAT, 1'b0); chk(r, 16'h0020);
		rd(telemetry_pkg::CMD_ADC_SEL, 1'b0); chk(r, 16'h0000);
		rd(telemetry_pkg::CMD_ADC_STAT, 1'b0); chk(r, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			ecc_corrected <= i[0];
			ecc_refresh <= 1'b1;
			@(posedge ref_clk);
			ecc_refresh <= 1'b0;
			rd(telemetry_pkg::CMD_EXTRA_STAT, 1'b0);
			chk(r, i[0] ? 16'h0000 : 16'h0020);
		end
		vmax = 16'h0000;
		for (int i = 0; i < 10; i++) begin
			v = (i == 9) ? 16'hffff : 16'($random(seed));
			adc(telemetry_pkg::PRM_VOUT0, v);
			if (v > vmax) vmax = v;
			rd(telemetry_pkg::CMD_VOUT, 1'b0); chk(r, v);
			rd(telemetry_pkg::CMD_VOUT_PEAK, 1'b0); chk(r, vmax);
		end
		adc(telemetry_pkg::PRM_VOUT0, 16'h0010);
		rd(telemetry_pkg::CMD_VOUT_PEAK, 1'b0); chk(r, vmax);
		wr(telemetry_pkg::CMD_PEAK_CLEAR, 16'h0000);
		adc(telemetry_pkg::PRM_VOUT0, 16'h0001);
		rd(telemetry_pkg::CMD_VOUT_PEAK, 1'b0); chk(r, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			v = 16'($random(seed));
			adc(prm[i], v);
			rd(cmds[i], i[1]); chk(r, v);
			rd(pks[i], i[1]); chk(r, v);
		end
		@(posedge ref_clk);
		freq_khz <= 16'($random(seed));
		duty_ch1 <= 16'($random(seed));
		duty_ch0 <= 16'($random(seed));
		rd(telemetry_pkg::CMD_FREQ, 1'b0); chk(r, freq_khz);
		rd(telemetry_pkg::CMD_DUTY, 1'b1); chk(r, duty_ch1);
		// zero output current leaves only the offsets in the input current
		adc(telemetry_pkg::PRM_IOUT1, 16'h0000);
		@(posedge ref_clk);
		iin_offset_ch0 <= 16'h0005;
		iin_offset_ch1 <= 16'h0009;
		rd(telemetry_pkg::CMD_CH_IIN, 1'b0); chk(16'(l11_int(r)), 16'h0005);
		rd(telemetry_pkg::CMD_CH_IIN, 1'b1); chk(16'(l11_int(r)), 16'h0009);
		rd(telemetry_pkg::CMD_IIN, 1'b0); chk(16'(l11_int(r)), 16'h000e);
		adc(telemetry_pkg::PRM_IOUT0, 16'h0002);
		adc(telemetry_pkg::PRM_VOUT0, 16'h0003);
		rd(telemetry_pkg::CMD_POUT, 1'b0); chk(16'(l11_int(r)), 16'h0006);
		for (int i = 0; i < 15; i++) begin
			c = (i == 14) ? 8'hff : 8'(i);
			resv = (i inside {2, 3, 7, 11, 14});
			wr(telemetry_pkg::CMD_ADC_SEL, {8'h00, c});
			chk({8'h00, adc_select}, resv ? 16'h0004 : {8'h00, c});
			chk({15'h0000, cml_invalid_data}, {15'h0000, resv});
		end
		wr(telemetry_pkg::CMD_ADC_SEL, 16'h000d);
		adc(telemetry_pkg::PRM_VOUT0, 16'h0100);
		adc(telemetry_pkg::PRM_IOUT1, 16'h0200);
		rd(telemetry_pkg::CMD_ADC_STAT, 1'b0); chk(r, 16'h0009);
		wr(telemetry_pkg::CMD_ADC_STAT, 16'h0001);
		rd(telemetry_pkg::CMD_ADC_STAT, 1'b0); chk(r, 16'h0008);
		wr(telemetry_pkg::CMD_ADC_SEL, 16'h0000);
		rd(telemetry_pkg::CMD_ADC_SEL, 1'b0); chk(r, 16'h0000);
		// mid-run reset: status must come from the report, peaks empty
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		ecc_corrected <= 1'b0;
		repeat (6) @(posedge link_clk);
		sys_rst <= 1'b0;
		rd(telemetry_pkg::CMD_EXTRA_STAT, 1'b0); chk(r, 16'h0020);
		rd(telemetry_pkg::CMD_VOUT_PEAK, 1'b0); chk(r, 16'h0000);
		chk({15'h0000, hung}, 16'h0000);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire

// ===== logic/telemetry_readback_bank.sv
/*
 telemetry read-back bank: measurement and peak storage, adc selection and
 conversion status, ecc status word, and a command port on the link clock.
 assumes adc results, duty, frequency and configuration arrive on ref_clk;
 the link side front end hands over one decoded command at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module telemetry_readback_bank (
	// clocks and reset
	input  wire logic        ref_clk,
	input  wire logic        link_clk,
	input  wire logic        sys_rst,
	// command port, link clock
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_write,
	input  wire logic        cmd_page,
	input  wire logic [15:0] cmd_wdata,
	output logic             rsp_valid,
	output logic [15:0]      rsp_data,
	// adc result stream
	input  wire logic        adc_valid,
	input  wire logic [7:0]  adc_param,
	input  wire logic [15:0] adc_value,
	output logic [7:0]       adc_select,
	output logic             cml_invalid_data,
	// converter state and configuration
	input  wire logic [15:0] duty_ch0,
	input  wire logic [15:0] duty_ch1,
	input  wire logic [15:0] freq_khz,
	input  wire logic [4:0]  vout_exponent,
	input  wire logic [15:0] iin_offset_ch0,
	input  wire logic [15:0] iin_offset_ch1,
	// eeprom ecc report
	input  wire logic        ecc_refresh,
	input  wire logic        ecc_corrected
);
	typedef enum logic [1:0] {
		LNK_IDLE = 2'b01,
		LNK_WAIT = 2'b10
	} link_state_t;

	// local copy so the link check bound stays a plain constant
	localparam int RSP_MAX = telemetry_pkg::RSP_MAX_LINK;

	// linear eleven-bit helpers, mantissa widened to 48 bits
	function automatic logic signed [47:0] l11_m(input logic [15:0] x);
		return {{37{x[10]}}, x[10:0]};
	endfunction

	function automatic logic signed [7:0] l11_e(input logic [15:0] x);
		return {{3{x[15]}}, x[15:11]};
	endfunction

	// limitation: exponent above 15 saturates, value then reads low
	function automatic logic [15:0] l11_pack(input logic signed [47:0] m,
		input logic signed [7:0] e);
		logic signed [47:0] mm;
		logic signed [7:0]  ee;
		mm = m;
		ee = e;
		for (int i = 0; i < 48; i++) begin
			if (mm > 48'sd1023 || mm < -48'sd1024 || ee < -8'sd16) begin
				mm = mm >>> 1;
				ee = ee + 8'sd1;
			end
		end
		if (ee > 8'sd15)
			ee = 8'sd15;
		return {ee[4:0], mm[10:0]};
	endfunction

	function automatic logic [15:0] l11_mul(input logic [15:0] a, input logic [15:0] b);
		logic signed [23:0] ma;
		logic signed [23:0] mb;
		logic signed [47:0] p;
		ma = 24'(l11_m(a));
		mb = 24'(l11_m(b));
		p = ma * mb;
		return l11_pack(p, l11_e(a) + l11_e(b));
	endfunction

	// align to the smaller exponent by shifting left, so nothing is lost
	function automatic logic signed [47:0] l11_al(input logic [15:0] x,
		input logic signed [7:0] emin);
		logic signed [7:0] d;
		d = l11_e(x) - emin;
		return l11_m(x) <<< d[5:0];
	endfunction

	function automatic logic signed [7:0] l11_emin(input logic [15:0] a,
		input logic [15:0] b);
		return (l11_e(a) < l11_e(b)) ? l11_e(a) : l11_e(b);
	endfunction

	function automatic logic [15:0] l11_add(input logic [15:0] a, input logic [15:0] b);
		logic signed [7:0] em;
		em = l11_emin(a, b);
		return l11_pack(l11_al(a, em) + l11_al(b, em), em);
	endfunction

	function automatic logic l11_gt(input logic [15:0] a, input logic [15:0] b);
		logic signed [7:0] em;
		em = l11_emin(a, b);
		return l11_al(a, em) > l11_al(b, em);
	endfunction

	function automatic logic sel_valid(input logic [7:0] s);
		case (s)
			telemetry_pkg::PRM_STANDARD, telemetry_pkg::PRM_VIN,
			telemetry_pkg::PRM_TDIE, telemetry_pkg::PRM_VOUT0,
			telemetry_pkg::PRM_IOUT0, telemetry_pkg::PRM_TEXT0,
			telemetry_pkg::PRM_VOUT1, telemetry_pkg::PRM_IOUT1,
			telemetry_pkg::PRM_TEXT1, telemetry_pkg::PRM_SHORT: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// link domain state
	link_state_t lnk_state_reg, lnk_state_next;
	logic        req_tgl_reg, req_tgl_next;
	logic [7:0]  hold_code_reg, hold_code_next;
	logic        hold_write_reg, hold_write_next;
	logic        hold_page_reg, hold_page_next;
	logic [15:0] hold_data_reg, hold_data_next;
	logic        ack_s1_reg, ack_s2_reg, ack_seen_reg;
	logic        rsp_valid_reg, rsp_valid_next;
	logic [15:0] rsp_data_reg, rsp_data_next;

	// ref domain state
	logic        req_s1_reg, req_s2_reg, req_seen_reg;
	logic        ack_tgl_reg, ack_tgl_next;
	logic [15:0] ans_reg, ans_next;
	logic [7:0]  sel_reg, sel_next;
	logic [3:0]  stat_reg, stat_next;
	logic        ecc_ok_reg, ecc_ok_next;
	logic        boot_reg;
	logic [15:0] vin_reg, vin_next, tdie_reg, tdie_next;
	logic [15:0] vin_pk_reg, vin_pk_next, tdie_pk_reg, tdie_pk_next;
	logic        vin_seen_reg, vin_seen_next, tdie_seen_reg, tdie_seen_next;
	logic [15:0] vout_reg [2], vout_next [2], iout_reg [2], iout_next [2];
	logic [15:0] text_reg [2], text_next [2];
	logic [15:0] vout_pk_reg [2], vout_pk_next [2], iout_pk_reg [2], iout_pk_next [2];
	logic [15:0] text_pk_reg [2], text_pk_next [2];
	logic [1:0]  vout_seen_reg, vout_seen_next, iout_seen_reg, iout_seen_next;
	logic [1:0]  text_seen_reg, text_seen_next;

	// derived values
	logic        new_req, do_write, peak_clear;
	logic        ch;
	logic [15:0] duty [2];
	logic [15:0] ch_iin [2];
	logic [15:0] pout [2];
	logic [15:0] iin_total;
	logic [15:0] info_word;

	// link side: accept, hold stable, wait for the answer toggle
	assign cmd_ready = (lnk_state_reg == LNK_IDLE);
	assign rsp_valid = rsp_valid_reg;
	assign rsp_data  = rsp_data_reg;

	always_comb begin
		lnk_state_next  = lnk_state_reg;
		req_tgl_next    = req_tgl_reg;
		hold_code_next  = hold_code_reg;
		hold_write_next = hold_write_reg;
		hold_page_next  = hold_page_reg;
		hold_data_next  = hold_data_reg;
		rsp_valid_next  = 1'b0;
		rsp_data_next   = rsp_data_reg;
		case (lnk_state_reg)
			LNK_IDLE: begin
				if (cmd_valid) begin
					hold_code_next  = cmd_code;
					hold_write_next = cmd_write;
					hold_page_next  = cmd_page;
					hold_data_next  = cmd_wdata;
					req_tgl_next    = ~req_tgl_reg;
					lnk_state_next  = LNK_WAIT;
				end
			end
			LNK_WAIT: begin
				// answer word is stable once the toggle is seen here
				if (ack_s2_reg != ack_seen_reg) begin
					rsp_data_next  = ans_reg;
					rsp_valid_next = 1'b1;
					lnk_state_next = LNK_IDLE;
				end
			end
			default: lnk_state_next = LNK_IDLE;
		endcase
	end

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lnk_state_reg  <= LNK_IDLE;
			req_tgl_reg    <= 1'b0;
			hold_code_reg  <= 8'h00;
			hold_write_reg <= 1'b0;
			hold_page_reg  <= 1'b0;
			hold_data_reg  <= 16'h0000;
			ack_s1_reg     <= 1'b0;
			ack_s2_reg     <= 1'b0;
			ack_seen_reg   <= 1'b0;
			rsp_valid_reg  <= 1'b0;
			rsp_data_reg   <= 16'h0000;
		end else begin
			lnk_state_reg  <= lnk_state_next;
			req_tgl_reg    <= req_tgl_next;
			hold_code_reg  <= hold_code_next;
			hold_write_reg <= hold_write_next;
			hold_page_reg  <= hold_page_next;
			hold_data_reg  <= hold_data_next;
			ack_s1_reg     <= ack_tgl_reg;
			ack_s2_reg     <= ack_s1_reg;
			ack_seen_reg   <= ack_s2_reg;
			rsp_valid_reg  <= rsp_valid_next;
			rsp_data_reg   <= rsp_data_next;
		end
	end

	// ref side: derived telemetry
	assign new_req    = req_s2_reg ^ req_seen_reg;
	assign do_write   = new_req & hold_write_reg;
	assign peak_clear = do_write & (hold_code_reg == telemetry_pkg::CMD_PEAK_CLEAR);
	assign duty[0]    = duty_ch0;
	assign duty[1]    = duty_ch1;

	for (genvar c = 0; c < 2; c++) begin : g_ch
		// input current = offset + iout * duty / 100
		assign ch_iin[c] = l11_add(c == 0 ? iin_offset_ch0 : iin_offset_ch1,
			l11_mul(l11_mul(iout_reg[c], duty[c]), telemetry_pkg::PCT_SCALE));
		// power from the stored pair, vout first lifted into linear eleven-bit
		assign pout[c] = l11_mul(l11_pack({32'h0, vout_reg[c]},
			{{3{vout_exponent[4]}}, vout_exponent}), iout_reg[c]);
	end

	assign iin_total = l11_add(ch_iin[0], ch_iin[1]);
	assign info_word = 16'({ecc_ok_reg, 5'h00});

	// reserved selection forces die temperature and holds the fault high
	assign adc_select       = sel_valid(sel_reg) ? sel_reg : telemetry_pkg::PRM_TDIE;
	assign cml_invalid_data = ~sel_valid(sel_reg);

	always_comb begin
		ch             = 1'b0;
		ack_tgl_next   = ack_tgl_reg;
		ans_next       = ans_reg;
		sel_next       = sel_reg;
		stat_next      = stat_reg;
		ecc_ok_next    = ecc_ok_reg;
		vin_next       = vin_reg;
		tdie_next      = tdie_reg;
		vin_pk_next    = vin_pk_reg;
		tdie_pk_next   = tdie_pk_reg;
		vin_seen_next  = vin_seen_reg & ~peak_clear;
		tdie_seen_next = tdie_seen_reg & ~peak_clear;
		vout_next      = vout_reg;
		iout_next      = iout_reg;
		text_next      = text_reg;
		vout_pk_next   = vout_pk_reg;
		iout_pk_next   = iout_pk_reg;
		text_pk_next   = text_pk_reg;
		vout_seen_next = vout_seen_reg & {2{~peak_clear}};
		iout_seen_next = iout_seen_reg & {2{~peak_clear}};
		text_seen_next = text_seen_reg & {2{~peak_clear}};
		// refreshed on release from reset and on each nvm reload
		if (boot_reg || ecc_refresh)
			ecc_ok_next = ~ecc_corrected;
		// command effects; writes to read-only codes are dropped
		if (do_write && hold_code_reg == telemetry_pkg::CMD_ADC_SEL)
			sel_next = hold_data_reg[7:0];
		if (do_write && hold_code_reg == telemetry_pkg::CMD_ADC_STAT)
			stat_next = stat_reg & ~hold_data_reg[3:0];
		// measurements; a set arriving with a clear wins
		if (adc_valid) begin
			case (adc_param)
				telemetry_pkg::PRM_VIN: begin
					vin_next = adc_value;
					if (!vin_seen_next || l11_gt(adc_value, vin_pk_reg))
						vin_pk_next = adc_value;
					vin_seen_next = 1'b1;
				end
				telemetry_pkg::PRM_TDIE: begin
					tdie_next = adc_value;
					if (!tdie_seen_next || l11_gt(adc_value, tdie_pk_reg))
						tdie_pk_next = adc_value;
					tdie_seen_next = 1'b1;
				end
				telemetry_pkg::PRM_VOUT0, telemetry_pkg::PRM_VOUT1: begin
					ch = (adc_param == telemetry_pkg::PRM_VOUT1);
					vout_next[ch] = adc_value;
					if (!vout_seen_next[ch] || adc_value > vout_pk_reg[ch])
						vout_pk_next[ch] = adc_value;
					vout_seen_next[ch] = 1'b1;
				end
				telemetry_pkg::PRM_IOUT0, telemetry_pkg::PRM_IOUT1: begin
					ch = (adc_param == telemetry_pkg::PRM_IOUT1);
					iout_next[ch] = adc_value;
					if (!iout_seen_next[ch] || l11_gt(adc_value, iout_pk_reg[ch]))
						iout_pk_next[ch] = adc_value;
					iout_seen_next[ch] = 1'b1;
				end
				telemetry_pkg::PRM_TEXT0, telemetry_pkg::PRM_TEXT1: begin
					ch = (adc_param == telemetry_pkg::PRM_TEXT1);
					text_next[ch] = adc_value;
					if (!text_seen_next[ch] || l11_gt(adc_value, text_pk_reg[ch]))
						text_pk_next[ch] = adc_value;
					text_seen_next[ch] = 1'b1;
				end
				default: ch = 1'b0;
			endcase
			if (sel_reg == telemetry_pkg::PRM_SHORT) begin
				if (adc_param == telemetry_pkg::PRM_VOUT0)
					stat_next[telemetry_pkg::ST_VOUT0_BIT] = 1'b1;
				if (adc_param == telemetry_pkg::PRM_IOUT0)
					stat_next[telemetry_pkg::ST_IOUT0_BIT] = 1'b1;
				if (adc_param == telemetry_pkg::PRM_VOUT1)
					stat_next[telemetry_pkg::ST_VOUT1_BIT] = 1'b1;
				if (adc_param == telemetry_pkg::PRM_IOUT1)
					stat_next[telemetry_pkg::ST_IOUT1_BIT] = 1'b1;
			end
		end
		// answer word; reads never touch the peaks
		if (new_req) begin
			ack_tgl_next = ~ack_tgl_reg;
			case (hold_code_reg)
				telemetry_pkg::CMD_VIN:        ans_next = vin_reg;
				telemetry_pkg::CMD_IIN:        ans_next = iin_total;
				telemetry_pkg::CMD_VOUT:       ans_next = vout_reg[hold_page_reg];
				telemetry_pkg::CMD_IOUT:       ans_next = iout_reg[hold_page_reg];
				telemetry_pkg::CMD_TEXT:       ans_next = text_reg[hold_page_reg];
				telemetry_pkg::CMD_TDIE:       ans_next = tdie_reg;
				telemetry_pkg::CMD_DUTY:       ans_next = duty[hold_page_reg];
				telemetry_pkg::CMD_FREQ:       ans_next = freq_khz;
				telemetry_pkg::CMD_POUT:       ans_next = pout[hold_page_reg];
				telemetry_pkg::CMD_IOUT_PEAK:  ans_next = iout_pk_reg[hold_page_reg];
				telemetry_pkg::CMD_ADC_SEL:    ans_next = {8'h00, sel_reg};
				telemetry_pkg::CMD_ADC_STAT:   ans_next = {12'h000, stat_reg};
				telemetry_pkg::CMD_VOUT_PEAK:  ans_next = vout_pk_reg[hold_page_reg];
				telemetry_pkg::CMD_VIN_PEAK:   ans_next = vin_pk_reg;
				telemetry_pkg::CMD_TEXT_PEAK:  ans_next = text_pk_reg[hold_page_reg];
				telemetry_pkg::CMD_CH_IIN:     ans_next = ch_iin[hold_page_reg];
				telemetry_pkg::CMD_TDIE_PEAK:  ans_next = tdie_pk_reg;
				telemetry_pkg::CMD_EXTRA_STAT: ans_next = info_word;
				default:                       ans_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_s1_reg    <= 1'b0;
			req_s2_reg    <= 1'b0;
			req_seen_reg  <= 1'b0;
			ack_tgl_reg   <= 1'b0;
			ans_reg       <= 16'h0000;
			sel_reg       <= telemetry_pkg::ADC_SEL_RST;
			stat_reg      <= telemetry_pkg::ADC_STAT_RST[3:0];
			ecc_ok_reg    <= 1'b0;
			boot_reg      <= 1'b1;
			vin_reg       <= 16'h0000;
			tdie_reg      <= 16'h0000;
			vin_pk_reg    <= 16'h0000;
			tdie_pk_reg   <= 16'h0000;
			vin_seen_reg  <= 1'b0;
			tdie_seen_reg <= 1'b0;
			vout_reg      <= '{16'h0000, 16'h0000};
			iout_reg      <= '{16'h0000, 16'h0000};
			text_reg      <= '{16'h0000, 16'h0000};
			vout_pk_reg   <= '{16'h0000, 16'h0000};
			iout_pk_reg   <= '{16'h0000, 16'h0000};
			text_pk_reg   <= '{16'h0000, 16'h0000};
			vout_seen_reg <= 2'h0;
			iout_seen_reg <= 2'h0;
			text_seen_reg <= 2'h0;
		end else begin
			req_s1_reg    <= req_tgl_reg;
			req_s2_reg    <= req_s1_reg;
			req_seen_reg  <= req_s2_reg;
			ack_tgl_reg   <= ack_tgl_next;
			ans_reg       <= ans_next;
			sel_reg       <= sel_next;
			stat_reg      <= stat_next;
			ecc_ok_reg    <= ecc_ok_next;
			boot_reg      <= 1'b0;
			vin_reg       <= vin_next;
			tdie_reg      <= tdie_next;
			vin_pk_reg    <= vin_pk_next;
			tdie_pk_reg   <= tdie_pk_next;
			vin_seen_reg  <= vin_seen_next;
			tdie_seen_reg <= tdie_seen_next;
			vout_reg      <= vout_next;
			iout_reg      <= iout_next;
			text_reg      <= text_next;
			vout_pk_reg   <= vout_pk_next;
			iout_pk_reg   <= iout_pk_next;
			text_pk_reg   <= text_pk_next;
			vout_seen_reg <= vout_seen_next;
			iout_seen_reg <= iout_seen_next;
			text_seen_reg <= text_seen_next;
		end
	end

	// checks
	a_ecc_refresh_value: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ecc_refresh |=> ecc_ok_reg == !$past(ecc_corrected))
		else $error("ecc status not refreshed from report");

	a_info_reserved_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		new_req && hold_code_reg == telemetry_pkg::CMD_EXTRA_STAT
		|=> ans_reg == {10'h000, $past(ecc_ok_reg), 5'h00} && ans_reg[15:6] == 10'h000)
		else $error("extra status word carries reserved bits");

	a_reserved_fallback: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!sel_valid(sel_reg) |-> adc_select == telemetry_pkg::PRM_TDIE && cml_invalid_data)
		else $error("reserved selection not handled");

	a_status_w1c: assert property (@(posedge ref_clk) disable iff (sys_rst)
		do_write && hold_code_reg == telemetry_pkg::CMD_ADC_STAT
		&& hold_data_reg[0] && !adc_valid |=> !stat_reg[0])
		else $error("status bit not cleared by write of one");

	a_short_loop_mark: assert property (@(posedge ref_clk) disable iff (sys_rst)
		adc_valid && adc_param == telemetry_pkg::PRM_IOUT1
		&& sel_reg == telemetry_pkg::PRM_SHORT |=> stat_reg[3])
		else $error("short loop conversion not marked");

	a_vin_peak_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!peak_clear && vin_seen_reg |=> !l11_gt($past(vin_pk_reg), vin_pk_reg))
		else $error("input voltage peak dropped without clear");

	a_peak_clear_empties: assert property (@(posedge ref_clk) disable iff (sys_rst)
		peak_clear && !adc_valid |=> vout_seen_reg == 2'h0 && !vin_seen_reg)
		else $error("peak clear did not empty peaks");

	a_vout_read_paged: assert property (@(posedge ref_clk) disable iff (sys_rst)
		new_req && hold_code_reg == telemetry_pkg::CMD_VOUT
		|=> ans_reg == vout_reg[$past(hold_page_reg)] || $past(adc_valid))
		else $error("output voltage read wrong page");

	a_link_answer: assert property (@(posedge link_clk) disable iff (sys_rst)
		cmd_valid && cmd_ready |=> !cmd_ready ##[1:RSP_MAX] rsp_valid)
		else $error("command not answered in time");
endmodule // telemetry_readback_bank
`default_nettype wire

// ===== shared/telemetry_pkg.sv
/*
 telemetry read-back bank: command codes, field positions, reset values,
 adc parameter codes and the linear-format scale constant.
 assumes a command decoder in front that hands over whole command transfers.
*/
package telemetry_pkg;
	// command codes
	localparam logic [7:0] CMD_VIN        = 8'h88;
	localparam logic [7:0] CMD_IIN        = 8'h89;
	localparam logic [7:0] CMD_VOUT       = 8'h8b;
	localparam logic [7:0] CMD_IOUT       = 8'h8c;
	localparam logic [7:0] CMD_TEXT       = 8'h8d;
	localparam logic [7:0] CMD_TDIE       = 8'h8e;
	localparam logic [7:0] CMD_DUTY       = 8'h94;
	localparam logic [7:0] CMD_FREQ       = 8'h95;
	localparam logic [7:0] CMD_POUT       = 8'h96;
	localparam logic [7:0] CMD_IOUT_PEAK  = 8'hd7;
	localparam logic [7:0] CMD_ADC_SEL    = 8'hd8;
	localparam logic [7:0] CMD_ADC_STAT   = 8'hda;
	localparam logic [7:0] CMD_VOUT_PEAK  = 8'hdd;
	localparam logic [7:0] CMD_VIN_PEAK   = 8'hde;
	localparam logic [7:0] CMD_TEXT_PEAK  = 8'hdf;
	localparam logic [7:0] CMD_CH_IIN     = 8'hed;
	localparam logic [7:0] CMD_TDIE_PEAK  = 8'hf4;
	localparam logic [7:0] CMD_EXTRA_STAT = 8'hb6;
	localparam logic [7:0] CMD_PEAK_CLEAR = 8'he3;
	// adc parameter codes, shared by selection byte and result stream
	localparam logic [7:0] PRM_STANDARD = 8'h00;
	localparam logic [7:0] PRM_VIN      = 8'h01;
	localparam logic [7:0] PRM_TDIE     = 8'h04;
	localparam logic [7:0] PRM_VOUT0    = 8'h05;
	localparam logic [7:0] PRM_IOUT0    = 8'h06;
	localparam logic [7:0] PRM_TEXT0    = 8'h08;
	localparam logic [7:0] PRM_VOUT1    = 8'h09;
	localparam logic [7:0] PRM_IOUT1    = 8'h0a;
	localparam logic [7:0] PRM_TEXT1    = 8'h0c;
	localparam logic [7:0] PRM_SHORT    = 8'h0d;
	// field positions and reset values
	localparam int         ECC_BIT       = 5;
	localparam int         ST_VOUT0_BIT  = 0;
	localparam int         ST_IOUT0_BIT  = 1;
	localparam int         ST_VOUT1_BIT  = 2;
	localparam int         ST_IOUT1_BIT  = 3;
	localparam logic [7:0] ADC_SEL_RST   = 8'h00;
	localparam logic [7:0] ADC_STAT_RST  = 8'h00;
	localparam logic [3:0] ADC_STAT_USED = 4'hf;
	// 655 * 2^-16, turns percent into a fraction
	localparam logic [15:0] PCT_SCALE    = 16'h828f;
	// bound on link cycles from accept to answer, for checking only
	localparam int         RSP_MAX_LINK  = 8;
endpackage
